// File: pkg/sram_host_pkg.sv
// Constants for the host-side controller of a 256K x 4 asynchronous static memory.
// Assumes a 100 MHz mclk; timing counts are derived from the slowest speed grade.
package sram_host_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_NS = 10;
  // ****************************************************************
  // Timing in ns, slowest grade; least times round up
  // ****************************************************************
  localparam int T_CYCLE_NS     = 12;
  localparam int T_PULSE_NS     = 10;
  localparam int T_DATA_SU_NS   = 6;
  localparam int T_ACCESS_NS    = 12;
  localparam int T_OE_ACCESS_NS = 6;
  localparam int T_FLOAT_NS     = 6;
  localparam int T_WR_OUT_NS    = 3;
  localparam int PULSE_CYC  = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC  = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC  = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_WSETUP = 6'b000010,
    ST_WPULSE = 6'b000100,
    ST_RACC   = 6'b001000,
    ST_RSAMP  = 6'b010000,
    ST_TURN   = 6'b100000
  } state_t;
endpackage

// File: pkg/sram_pins_if.sv
// Interface carrying the memory pins between the sequencer and the pad stage.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
interface sram_pins_if;
  import sram_host_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              chip_on_n;
  logic              store_strobe_n;
  logic              output_drive_n;
  logic [DATA_W-1:0] wdata;
  logic              data_oe;
  logic [DATA_W-1:0] rdata_sync;
  modport seq (output addr, chip_on_n, store_strobe_n, output_drive_n, wdata, data_oe,
               input rdata_sync);
  modport pad (input addr, chip_on_n, store_strobe_n, output_drive_n, wdata, data_oe,
               output rdata_sync);
endinterface
`default_nettype wire

// File: rtl/sram_host_ctrl.sv
// Host controller that reads and writes a 256K x 4 asynchronous static memory.
// Assumes one request at a time on a valid/ready port and a memory fed on its pins.
// How it works
// - Each write cycle lasts at least 12 ns at the slowest grade.
// - Strobe falls no earlier than valid address.
// - Address held valid at least 10 ns before strobe rises.
// - Strobe held low at least 10 ns.
// - Write data valid at least 6 ns before strobe rises, zero hold.
// - Host may change data right after strobe rises.
// - Address may change right after write ends.
// - Enable-controlled write: address valid before chip_on_n falls, held.
// - Enable-controlled write: chip_on_n low at least 9 ns.
// - Enable-controlled write: data valid 6 ns before chip_on_n rises.
// - Host avoids contention on the shared data lines.
`timescale 1ns/100ps
`default_nettype none
module sram_host_ctrl #(
  parameter int ADDR_BITS = 18,
  parameter int DATA_BITS = 4
) (
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic                            req_write,
  input  wire logic [ADDR_BITS-1:0]            req_addr,
  input  wire logic [DATA_BITS-1:0]            req_wdata,
  output logic                                 rsp_valid,
  output logic [DATA_BITS-1:0]                 rsp_rdata,
  output logic [ADDR_BITS-1:0]                 addr_lines,
  output logic                                 chip_on_n,
  output logic                                 store_strobe_n,
  output logic                                 output_drive_n,
  input  wire logic [DATA_BITS-1:0]            data_pins_i,
  output logic [DATA_BITS-1:0]                 data_pins_o,
  output logic [DATA_BITS-1:0]                 data_pins_oe
);
  import sram_host_pkg::*;
  sram_pins_if pins ();
  state_t            state_q;
  state_t            state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              ce_n_q;
  logic              we_n_q;
  logic              oe_n_q;
  logic              doe_q;
  logic              rsp_valid_q;
  logic [DATA_W-1:0] rdata_q;
  logic              cnt_done;
  sram_pad_sync u_pad (
    .mclk        (mclk),
    .resetn      (resetn),
    .data_pins_i (data_pins_i),
    .pins        (pins)
  );
  assign cnt_done  = (cnt_q == CNT_ZERO);
  assign req_ready = (state_q == ST_IDLE);
  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_done ? CNT_ZERO : cnt_q - CNT_ONE;
    case (state_q)
      ST_IDLE: begin
        if (req_valid && req_write) begin
          state_d = ST_WSETUP;
          cnt_d   = CNT_ZERO;
        end else if (req_valid) begin
          state_d = ST_RACC;
          cnt_d   = CNT_W'(ACCESS_CYC + FLOAT_CYC);
        end
      end
      ST_WSETUP: begin
        state_d = ST_WPULSE;
        cnt_d   = CNT_W'(PULSE_CYC - 1);
      end
      ST_WPULSE: begin
        if (cnt_done) begin
          state_d = ST_TURN;
          cnt_d   = CNT_W'(CYCLE_CYC - 1);
        end
      end
      ST_RACC: begin
        if (cnt_done) begin
          state_d = ST_RSAMP;
        end
      end
      ST_RSAMP: begin
        state_d = ST_TURN;
        cnt_d   = CNT_W'(FLOAT_CYC);
      end
      ST_TURN: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = CNT_ZERO;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end
  // ****************************************************************
  // Address and write data latch
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_q  <= 18'h00000;
      wdata_q <= 4'h0;
    end else if (req_ready && req_valid) begin
      addr_q  <= ADDR_W'(req_addr);
      wdata_q <= DATA_W'(req_wdata);
    end
  end
  // ****************************************************************
  // Control pins, all from flops
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_q  <= 1'b0;
    end else begin
      // enable low with the strobe pulse
      ce_n_q <= !(state_d == ST_WPULSE || state_d == ST_RACC || state_d == ST_RSAMP);
      we_n_q <= !(state_d == ST_WPULSE);
      // read only with strobe high; otherwise floats
      oe_n_q <= !(state_d == ST_RACC || state_d == ST_RSAMP);
      // data driven from setup through strobe rise, never while reading
      // data released as enable and strobe rise
      doe_q  <= (state_d == ST_WSETUP || state_d == ST_WPULSE);
    end
  end
  // ****************************************************************
  // Read capture; synchronised pins, so access plus two flops
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_q <= 1'b0;
      rdata_q     <= 4'h0;
    end else begin
      rsp_valid_q <= (state_q == ST_RSAMP);
      if (state_q == ST_RSAMP) begin
        rdata_q <= pins.rdata_sync;
      end
    end
  end
  assign pins.addr           = addr_q;
  assign pins.chip_on_n      = ce_n_q;
  assign pins.store_strobe_n = we_n_q;
  assign pins.output_drive_n = oe_n_q;
  assign pins.wdata          = wdata_q;
  assign pins.data_oe        = doe_q;
  assign addr_lines     = ADDR_BITS'(addr_q);
  assign chip_on_n      = ce_n_q;
  assign store_strobe_n = we_n_q;
  assign output_drive_n = oe_n_q;
  assign data_pins_o    = DATA_BITS'(wdata_q);
  assign data_pins_oe   = {DATA_BITS{doe_q}};
  assign rsp_valid      = rsp_valid_q;
  assign rsp_rdata      = DATA_BITS'(rdata_q);
endmodule
`default_nettype wire

// File: rtl/sram_pad_sync.sv
// Pad stage: registered data input, two-flop synchroniser of the data pins.
// Assumes pins are driven straight from the sequencer's flops.
`timescale 1ns/100ps
`default_nettype none
module sram_pad_sync (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic [sram_host_pkg::DATA_W-1:0] data_pins_i,
  sram_pins_if.pad                           pins
);
  import sram_host_pkg::*;
  logic [DATA_W-1:0] meta_q;
  logic [DATA_W-1:0] sync_q;
  // ****************************************************************
  // Two-flop synchroniser; pins are asynchronous to mclk
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= data_pins_i;
      sync_q <= meta_q;
    end
  end
  assign pins.rdata_sync = sync_q;
endmodule
`default_nettype wire

// File: tb/sram_device_model.sv
// Behavioural 256K x 4 static memory on the controller's far side.
// Assumes the bench resolves the shared data wire.
`timescale 1ns/100ps
`default_nettype none
module sram_device_model (
  input  wire logic [17:0] addr_lines,
  input  wire logic        chip_on_n,
  input  wire logic        store_strobe_n,
  input  wire logic        output_drive_n,
  input  wire logic [3:0]  data_pins_i,
  output logic      [3:0]  mem_dq
);
  logic [3:0]  mem [int];
  logic [21:0] seen = 22'h5;
  logic        wr_q = 1'b0;
  logic        drv = 1'b0;
  wire         rd = !chip_on_n && !output_drive_n && store_strobe_n;
  // Delayed copy: data must be there before the write ends
  always @(data_pins_i, addr_lines) seen <= #2 {addr_lines, data_pins_i};
  // store as the low overlap ends
  always @(chip_on_n, store_strobe_n) begin
    if (wr_q && (chip_on_n || store_strobe_n)) mem[seen[21:4]] = seen[3:0];
    wr_q = !chip_on_n && !store_strobe_n;
  end
  always @(rd) drv <= #5 rd;
  // Released lines show a changing pattern, not the last value
  always @* mem_dq = (drv && rd) ? (mem.exists(addr_lines) ? mem[addr_lines] : 4'h0) : ~seen[3:0];
endmodule
`default_nettype wire

// File: tb/sram_host_checks_assertions.sv
// Checks on the host memory controller pins and handshake.
// Bound into sram_host_ctrl; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sram_host_checks (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_write,
  input wire logic        rsp_valid,
  input wire logic [17:0] addr_lines,
  input wire logic        chip_on_n,
  input wire logic        store_strobe_n,
  input wire logic        output_drive_n,
  input wire logic [3:0]  data_pins_o,
  input wire logic [3:0]  data_pins_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence wr_pulse; $fell(store_strobe_n) ##1 $rose(store_strobe_n); endsequence
  sequence rd_span; !output_drive_n [*5] ##1 output_drive_n; endsequence
  a_write_overlap: assert property ($fell(store_strobe_n) |-> $fell(chip_on_n))
    else $error("strobe without enable");
  a_write_setup: assert property ($fell(store_strobe_n) |-> $stable(addr_lines)
    && $stable(data_pins_o) && data_pins_oe == 4'hF) else $error("setup short");
  a_pulse_end: assert property ($fell(store_strobe_n) |=> $rose(chip_on_n))
    else $error("pulse length");
  a_data_release: assert property (wr_pulse |-> data_pins_oe == 4'h0)
    else $error("data kept");
  a_no_contend: assert property (!output_drive_n |-> data_pins_oe == 4'h0)
    else $error("host drives in read");
  a_read_span: assert property ($fell(output_drive_n) |-> !chip_on_n ##0 rd_span)
    else $error("read span");
  a_read_answer: assert property (req_valid && req_ready && !req_write
    |-> ##6 rsp_valid ##1 !rsp_valid) else $error("read answer");
  a_write_done: assert property (req_valid && req_ready && req_write
    |=> !req_ready [*4] ##1 req_ready) else $error("write turnaround");
endmodule
bind sram_host_ctrl sram_host_checks u_checks (
  .mclk           (mclk),
  .resetn         (resetn),
  .req_valid      (req_valid),
  .req_ready      (req_ready),
  .req_write      (req_write),
  .rsp_valid      (rsp_valid),
  .addr_lines     (addr_lines),
  .chip_on_n      (chip_on_n),
  .store_strobe_n (store_strobe_n),
  .output_drive_n (output_drive_n),
  .data_pins_o    (data_pins_o),
  .data_pins_oe   (data_pins_oe)
);
`default_nettype wire

// File: tb/sram_host_ctrl_tb.sv
// Bench: controller against a behavioural memory and a reference array.
// Assumes answer times follow the package timing counts.
`timescale 1ns/100ps
`default_nettype none
module sram_host_ctrl_tb;
  import sram_host_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        req_ready, rsp_valid, chip_on_n, store_strobe_n, output_drive_n;
  logic [17:0] req_addr = 18'h00000, addr_lines, addr_q [$];
  logic [3:0]  req_wdata = 4'h0, rsp_rdata, data_pins_o, data_pins_oe, mem_dq, ref_mem [int];
  logic [31:0] rng = 32'h0000C8FE;
  wire  [3:0]  data_pins_i;
  int          error_cnt = 0, num_checks = 0;
  always #5 mclk = ~mclk;
  assign data_pins_i = (data_pins_oe & data_pins_o) | (~data_pins_oe & mem_dq);
  sram_host_ctrl u_sram_host_ctrl (
    .mclk           (mclk),
    .resetn         (resetn),
    .req_valid      (req_valid),
    .req_ready      (req_ready),
    .req_write      (req_write),
    .req_addr       (req_addr),
    .req_wdata      (req_wdata),
    .rsp_valid      (rsp_valid),
    .rsp_rdata      (rsp_rdata),
    .addr_lines     (addr_lines),
    .chip_on_n      (chip_on_n),
    .store_strobe_n (store_strobe_n),
    .output_drive_n (output_drive_n),
    .data_pins_i    (data_pins_i),
    .data_pins_o    (data_pins_o),
    .data_pins_oe   (data_pins_oe)
  );
  sram_device_model u_sram_device_model (
    .addr_lines     (addr_lines),
    .chip_on_n      (chip_on_n),
    .store_strobe_n (store_strobe_n),
    .output_drive_n (output_drive_n),
    .data_pins_i    (data_pins_i),
    .mem_dq         (mem_dq)
  );
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic check_word(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_cycles(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Entered at a falling edge; request held until the edge that takes it
  task automatic xfer(input logic w, input logic [17:0] a, input logic [3:0] d);
    int n;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    for (n = 0; n < 9 && req_ready !== 1'b1; n++) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    if (w) ref_mem[a] = d;
    for (n = 0; n < 15 && (w ? req_ready : rsp_valid) !== 1'b1; n++) @(negedge mclk);
    if (w) check_cycles("write cycles", 8'(1 + PULSE_CYC + CYCLE_CYC), n[7:0]);
    else check_cycles("read cycles", 8'(ACCESS_CYC + FLOAT_CYC + 2), n[7:0]);
    if (!w) check_word("read data", ref_mem.exists(a) ? ref_mem[a] : 4'h0, rsp_rdata);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, 18'h3FFF0 + 18'(i), i[3:0]);
      xfer(1'b0, 18'h3FFF0 + 18'(i), 4'h0);
    end
    for (int i = 0; i < 60; i++) begin
      rng = xs(rng);
      if (rng[0] || addr_q.size() == 0) begin
        addr_q.push_back(rng[25:8]);
        xfer(1'b1, rng[25:8], rng[7:4]);
      end else begin
        xfer(1'b0, addr_q[rng[31:8] % addr_q.size()], 4'h0);
      end
    end
    $display("test transfers done");
    for (int n = 0; n < 9 && req_ready !== 1'b1; n++) @(negedge mclk);
    req_write = 1'b1;
    req_addr = 18'h15555;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    resetn = 1'b0;
    @(negedge mclk);
    check_word("idle controls", 4'hF, {chip_on_n, store_strobe_n, output_drive_n, req_ready});
    check_word("drive enables", 4'h0, data_pins_oe);
    resetn = 1'b1;
    repeat (300) @(negedge mclk);
    xfer(1'b0, 18'h3FFFF, 4'h0);
    $display("test reset and retention done");
    complete_run();
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
